// File: hscr_regs.v
// calibration, address, identification and result register bank of a 3-axis hall sensor
`timescale 1ns/1ps
`include "hscr_defines.vh"
// Contract
// - gain byte is unsigned fraction code/256 applied to selected axis
// - gain code zero is applied as unity gain
// - gained axis chosen by gain axis select and angle axes enable
// - first offset code is signed 8-bit, -128 to +127 steps, on first axis
// - second offset code is signed 8-bit, applied to second axis
// - offset correction equals signed code times one result lsb
// - power-up loads factory address 35h into address field
// - programmed address lost on power cycle; host rewrites it
// - update enable 1 adopts bits 7:1 as address; 0 keeps current
// - read-only 2-bit variant code in bits 1-0, others reserved
// - read-only 16-bit maker code, low byte Eh, high byte Fh
// - temperature result high byte at 10h, low byte at 11h
// - x-axis result high byte at 12h, low byte at 13h
// - result bytes reset to zero before any conversion
// - gain register at offset 9h, reset zero
module hscr_regs #(
  parameter [1:0]  VARIANT_CODE = 2'h1,     // ordered range variant
  parameter [15:0] MAKER_CODE   = 16'hA5C3  // arbitrary value, not a real maker code
) (
  input  wire        clk_sys_in,            // system clock, 200 MHz
  input  wire        nrst_in,               // async reset, active low (power-on)
  input  wire        clk_en_in,             // clock enable, freezes all state when low
  input  wire        reg_wr_in,             // register write strobe
  input  wire        reg_rd_in,             // register read strobe
  input  wire [7:0]  reg_addr_in,           // register byte offset
  input  wire [7:0]  reg_wdata_in,          // write data
  output reg  [7:0]  reg_rdata_out,         // read data, registered
  output reg         reg_rvalid_out,        // read data valid pulse
  input  wire        angle_en_in,           // angle axes enable from angle config
  input  wire        gain_axis_select_in,   // gain axis select bit from sensor config
  input  wire        temp_done_in,          // temperature conversion complete pulse
  input  wire [15:0] temperature_result_in, // new temperature result
  input  wire        x_done_in,             // x-axis conversion complete pulse
  input  wire [15:0] x_axis_result_in,      // new x-axis result
  output reg  [8:0]  gain_factor_out,       // applied gain, unsigned, 9'h100 = 1.0
  output reg  [1:0]  gain_axis_out,         // axis receiving gain: 0 none, 1 first, 2 second
  output reg  [15:0] first_offset_out,      // first-axis offset in result lsbs, signed
  output reg  [15:0] second_offset_out,     // second-axis offset in result lsbs, signed
  output reg  [6:0]  bus_target_addr_out    // active bus target address
);

  localparam [1:0] AXIS_NONE   = 2'h0;
  localparam [1:0] AXIS_FIRST  = 2'h1;
  localparam [1:0] AXIS_SECOND = 2'h2;

  // register storage, one flip-flop byte or word per writable or result register; id registers are constants
  reg [7:0]  axis_gain_fraction_ff;
  reg [7:0]  first_axis_offset_ff;
  reg [7:0]  second_axis_offset_ff;
  reg [7:0]  bus_target_address_ff;
  reg [15:0] temperature_result_ff;
  reg [15:0] x_axis_result_ff;
  reg [6:0]  active_addr_ff;
  reg [7:0]  nxt_rdata;
  // next values and decoded write strobes
  reg [8:0]  nxt_gain_factor;
  reg [1:0]  nxt_gain_axis;
  reg [6:0]  nxt_active_addr;
  wire       gain_wr_hit;
  wire       ofs1_wr_hit;
  wire       ofs2_wr_hit;
  wire       addr_wr_hit;

  // sign-extend an offset code to result width; one code step equals one result lsb
  function [15:0] hscr_ofs_ext;
    input [7:0] code;
    begin
      hscr_ofs_ext = {{`HSCR_SIGN_REP{code[`HSCR_SIGN_BIT]}}, code};
    end
  endfunction

  // write strobe gated by address, shared by all writable registers
  function hscr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      hscr_hit = wr && (addr == target);
    end
  endfunction

  // per-register write strobes; id and result offsets get none, so writes there are dropped
  assign gain_wr_hit = hscr_hit(reg_wr_in, reg_addr_in, `HSCR_OFF_GAIN);
  assign ofs1_wr_hit = hscr_hit(reg_wr_in, reg_addr_in, `HSCR_OFF_OFS1);
  assign ofs2_wr_hit = hscr_hit(reg_wr_in, reg_addr_in, `HSCR_OFF_OFS2);
  assign addr_wr_hit = hscr_hit(reg_wr_in, reg_addr_in, `HSCR_OFF_ADDR);

  // gain fraction register; its zero reset value is read by the datapath as unity
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      axis_gain_fraction_ff <= `HSCR_RST_BYTE;
    end
    else if (clk_en_in)
    begin
      if (gain_wr_hit)
      begin
        axis_gain_fraction_ff <= reg_wdata_in;
      end
    end
  end

  // first-axis offset code, kept raw; sign handling happens at the output
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      first_axis_offset_ff <= `HSCR_RST_BYTE;
    end
    else if (clk_en_in)
    begin
      if (ofs1_wr_hit)
      begin
        first_axis_offset_ff <= reg_wdata_in;
      end
    end
  end

  // second-axis offset code, kept raw like the first
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      second_axis_offset_ff <= `HSCR_RST_BYTE;
    end
    else if (clk_en_in)
    begin
      if (ofs2_wr_hit)
      begin
        second_axis_offset_ff <= reg_wdata_in;
      end
    end
  end

  // address register; reset holds the factory address with update enable cleared
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bus_target_address_ff <= `HSCR_RST_ADDR_REG;
    end
    else if (clk_en_in)
    begin
      if (addr_wr_hit)
      begin
        bus_target_address_ff <= reg_wdata_in;
      end
    end
  end

  // adopt the new address only while update enable is set, so a partial edit is harmless
  always @*
  begin
    nxt_active_addr = active_addr_ff;
    if (bus_target_address_ff[`HSCR_ADDR_UPD_BIT])
    begin
      nxt_active_addr = bus_target_address_ff[`HSCR_ADDR_MSB:`HSCR_ADDR_LSB];
    end
  end

  // adopted address; power-on reset brings back the factory value, so the host must rewrite it
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      active_addr_ff <= `HSCR_FACTORY_ADDR;
    end
    else if (clk_en_in)
    begin
      active_addr_ff <= nxt_active_addr;
    end
  end

  // temperature result capture; read-only from the bus side, so writes never reach here
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      temperature_result_ff <= `HSCR_RST_WORD;
    end
    else if (clk_en_in)
    begin
      if (temp_done_in)
      begin
        temperature_result_ff <= temperature_result_in;
      end
    end
  end

  // x-axis result capture; no snapshot, so a done pulse between byte reads can tear the word
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      x_axis_result_ff <= `HSCR_RST_WORD;
    end
    else if (clk_en_in)
    begin
      if (x_done_in)
      begin
        x_axis_result_ff <= x_axis_result_in;
      end
    end
  end

  // read mux; id and result offsets decode only on reads, writes to them fall through
  always @*
  begin
    nxt_rdata = `HSCR_RST_BYTE;
    case (reg_addr_in)
      // calibration and address readback
      `HSCR_OFF_GAIN:      nxt_rdata = axis_gain_fraction_ff;
      `HSCR_OFF_OFS1:      nxt_rdata = first_axis_offset_ff;
      `HSCR_OFF_OFS2:      nxt_rdata = second_axis_offset_ff;
      `HSCR_OFF_ADDR:      nxt_rdata = bus_target_address_ff;
      // identification, fixed when the variant is built
      `HSCR_OFF_VARIANT:   nxt_rdata = {`HSCR_RSVD_ZERO6, VARIANT_CODE};
      `HSCR_OFF_MAKER_LO:  nxt_rdata = MAKER_CODE[`HSCR_BYTE_LO_MSB:`HSCR_BYTE_LO_LSB];
      `HSCR_OFF_MAKER_HI:  nxt_rdata = MAKER_CODE[`HSCR_BYTE_HI_MSB:`HSCR_BYTE_HI_LSB];
      // conversion results, high byte at the lower offset
      `HSCR_OFF_TEMP_HI:   nxt_rdata = temperature_result_ff[`HSCR_BYTE_HI_MSB:`HSCR_BYTE_HI_LSB];
      `HSCR_OFF_TEMP_LO:   nxt_rdata = temperature_result_ff[`HSCR_BYTE_LO_MSB:`HSCR_BYTE_LO_LSB];
      `HSCR_OFF_X_HI:      nxt_rdata = x_axis_result_ff[`HSCR_BYTE_HI_MSB:`HSCR_BYTE_HI_LSB];
      `HSCR_OFF_X_LO:      nxt_rdata = x_axis_result_ff[`HSCR_BYTE_LO_MSB:`HSCR_BYTE_LO_LSB];
      default:             nxt_rdata = `HSCR_RST_BYTE;
    endcase
  end

  // read valid pulse follows every accepted read strobe by one cycle
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reg_rvalid_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // read data held until the next read, so a slow host may still pick it up
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reg_rdata_out <= `HSCR_RST_BYTE;
    end
    else if (clk_en_in)
    begin
      if (reg_rd_in)
      begin
        reg_rdata_out <= nxt_rdata;
      end
    end
  end

  // zero code would null the axis, so it stands for unity instead
  always @*
  begin
    if (axis_gain_fraction_ff == `HSCR_RST_BYTE)
    begin
      nxt_gain_factor = `HSCR_UNITY_GAIN;
    end
    else
    begin
      nxt_gain_factor = {1'b0, axis_gain_fraction_ff};
    end
  end

  // gain only meaningful with angle axes enabled; select picks first or second
  always @*
  begin
    if (!angle_en_in)
    begin
      nxt_gain_axis = AXIS_NONE;
    end
    else if (gain_axis_select_in)
    begin
      nxt_gain_axis = AXIS_SECOND;
    end
    else
    begin
      nxt_gain_axis = AXIS_FIRST;
    end
  end

  // gain factor registered so the datapath sees glitch-free values
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      gain_factor_out <= `HSCR_UNITY_GAIN;
    end
    else if (clk_en_in)
    begin
      gain_factor_out <= nxt_gain_factor;
    end
  end

  // gained axis registered; it trails the axis inputs by one cycle
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      gain_axis_out <= AXIS_NONE;
    end
    else if (clk_en_in)
    begin
      gain_axis_out <= nxt_gain_axis;
    end
  end

  // first offset in result lsbs; one code step is one lsb, so a plain sign extension suffices
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      first_offset_out <= `HSCR_RST_WORD;
    end
    else if (clk_en_in)
    begin
      first_offset_out <= hscr_ofs_ext(first_axis_offset_ff);
    end
  end

  // second offset in result lsbs, same scaling as the first
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      second_offset_out <= `HSCR_RST_WORD;
    end
    else if (clk_en_in)
    begin
      second_offset_out <= hscr_ofs_ext(second_axis_offset_ff);
    end
  end

  // active address output trails the adopted address by one cycle
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bus_target_addr_out <= `HSCR_FACTORY_ADDR;
    end
    else if (clk_en_in)
    begin
      bus_target_addr_out <= active_addr_ff;
    end
  end

endmodule // hscr_regs

// File: hscr_defines.vh
// register offsets, reset values and field positions for the calibration, id and result bank
`ifndef HSCR_DEFINES_VH
`define HSCR_DEFINES_VH
`define HSCR_OFF_GAIN       8'h09
`define HSCR_OFF_OFS1       8'h0A
`define HSCR_OFF_OFS2       8'h0B
`define HSCR_OFF_ADDR       8'h0C
`define HSCR_OFF_VARIANT    8'h0D
`define HSCR_OFF_MAKER_LO   8'h0E
`define HSCR_OFF_MAKER_HI   8'h0F
`define HSCR_OFF_TEMP_HI    8'h10
`define HSCR_OFF_TEMP_LO    8'h11
`define HSCR_OFF_X_HI       8'h12
`define HSCR_OFF_X_LO       8'h13
`define HSCR_RST_BYTE       8'h00
`define HSCR_RST_WORD       16'h0000
`define HSCR_RST_ADDR_REG   8'h6A
`define HSCR_FACTORY_ADDR   7'h35
`define HSCR_UNITY_GAIN     9'h100
`define HSCR_ADDR_UPD_BIT   0
`define HSCR_VARIANT_MSB    1
`define HSCR_RSVD_ZERO6     6'h00
`define HSCR_ADDR_MSB       7
`define HSCR_ADDR_LSB       1
`define HSCR_SIGN_BIT       7
`define HSCR_SIGN_REP       8
`define HSCR_BYTE_LO_MSB    7
`define HSCR_BYTE_LO_LSB    0
`define HSCR_BYTE_HI_MSB    15
`define HSCR_BYTE_HI_LSB    8
`endif

// File: hscr_regs_asserts.sv
// assertions on the calibration, address and result register bank
`timescale 1ns/1ps
module hscr_regs_asserts (
  input wire        clk_sys_in, // clock
  input wire        nrst_in, // reset
  input wire        reg_wr_in, // write
  input wire [7:0]  reg_addr_in, // offset
  input wire [7:0]  reg_wdata_in, // data
  input wire        angle_en_in, // angle on
  input wire        gain_axis_select_in, // axis pick
  input wire [8:0]  gain_factor_out, // gain
  input wire [1:0]  gain_axis_out, // gained axis
  input wire [15:0] first_offset_out, // offset 1
  input wire [15:0] second_offset_out, // offset 2
  input wire [6:0]  bus_target_addr_out // address
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // writes decoded per offset
  wire wg = reg_wr_in && reg_addr_in == 8'h09;
  wire wa = reg_wr_in && reg_addr_in == 8'h0A;
  wire wc = reg_wr_in && reg_addr_in == 8'h0C;
  wire wb = reg_wr_in && reg_addr_in == 8'h0B;
  // derived outputs trail the register write by two edges
  AST_GAIN_UNITY: assert property (wg && reg_wdata_in == 8'h00
    |-> ##2 gain_factor_out == 9'h100) else $error("zero gain not unity");
  AST_GAIN_FRAC: assert property (wg && reg_wdata_in != 8'h00
    |-> ##2 gain_factor_out == {1'h0, $past(reg_wdata_in, 2)}) else $error("gain wrong");
  AST_OFS_ONE: assert property (wa
    |-> ##2 $signed(first_offset_out) == $signed($past(reg_wdata_in, 2))) else $error("offset 1 wrong");
  AST_OFS_TWO: assert property (wb
    |-> ##2 $signed(second_offset_out) == $signed($past(reg_wdata_in, 2))) else $error("offset 2 wrong");
  // axis inputs must sit still one edge so a registered output may follow
  AST_AXIS_OFF: assert property (!angle_en_in && $stable(angle_en_in)
    |=> gain_axis_out == 2'h0) else $error("axis gained while angle off");
  AST_AXIS_ON: assert property (angle_en_in && $stable(angle_en_in) && $stable(gain_axis_select_in)
    |=> gain_axis_out == ($past(gain_axis_select_in) ? 2'h2 : 2'h1)) else $error("wrong gained axis");
  AST_ADDR_ADOPT: assert property (wc && reg_wdata_in[0]
    |-> ##3 bus_target_addr_out == $past(reg_wdata_in[7:1], 3)) else $error("address not adopted");
  AST_ADDR_KEEP: assert property (wc && !reg_wdata_in[0]
    |=> ##1 $stable(bus_target_addr_out)[*3]) else $error("address moved without enable");
endmodule // hscr_regs_asserts
bind hscr_regs hscr_regs_asserts chk (.clk_sys_in, .nrst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .angle_en_in,
  .gain_axis_select_in, .gain_factor_out, .gain_axis_out, .first_offset_out, .second_offset_out, .bus_target_addr_out);

// File: hscr_host_model.sv
// host side model issuing register writes and reads
`timescale 1ns/1ps
module hscr_host_model (
  input  wire       clk_in, // clock
  output reg        wr_out, // write strobe
  output reg        rd_out, // read strobe
  output reg  [7:0] addr_out, // offset
  output reg  [7:0] data_out // write data
);
  initial {wr_out, rd_out, addr_out, data_out} = 18'h0;
  // strobe held one cycle; offset and data inverted once released so stale values never match
  task put(input w, input [7:0] a, input [7:0] d);
  begin
    @(posedge clk_in);
    #1 {wr_out, rd_out, addr_out, data_out} = {w, !w, a, d};
    @(posedge clk_in);
    #1 {wr_out, rd_out, addr_out, data_out} = {2'h0, ~a, ~d};
  end
  endtask
endmodule // hscr_host_model

// File: hscr_regs_bench.sv
// self-checking bench for the calibration, address and result register bank
`timescale 1ns/1ps
module hscr_regs_bench;
  localparam [15:0] MK = 16'h5A3C; // arbitrary maker code
  reg clk_sys_in = 1'h0, nrst_in = 1'h0, angle_en_in = 1'h0, gain_axis_select_in = 1'h0;
  reg temp_done_in = 1'h0, x_done_in = 1'h0;
  reg [31:0] rnd = 32'h0;
  wire [15:0] temperature_result_in = rnd[15:0], x_axis_result_in = rnd[31:16], first_offset_out, second_offset_out;
  wire reg_wr_in, reg_rd_in, reg_rvalid_out;
  wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire [8:0] gain_factor_out;
  wire [1:0] gain_axis_out;
  wire [6:0] bus_target_addr_out;
  reg [7:0] exp_q[$];
  integer err_total = 0, checks_done = 0, seed = 29, i;
  hscr_regs #(.VARIANT_CODE(2'h2), .MAKER_CODE(MK)) DUT (.clk_sys_in, .nrst_in, .clk_en_in(1'h1), .reg_wr_in,
    .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .angle_en_in, .gain_axis_select_in,
    .temp_done_in, .temperature_result_in, .x_done_in, .x_axis_result_in, .gain_factor_out, .gain_axis_out,
    .first_offset_out, .second_offset_out, .bus_target_addr_out);
  hscr_host_model host (.clk_in(clk_sys_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in), .addr_out(reg_addr_in),
    .data_out(reg_wdata_in));
  always #2.5 clk_sys_in = ~clk_sys_in;
  // power-on contents from offset 09h upward; past 13h nothing is mapped
  function [7:0] rst_val(input integer k);
    rst_val = (k == 3) ? 8'h6A : (k == 4) ? 8'h02 : (k == 5) ? MK[7:0] : (k == 6) ? MK[15:8] : 8'h00;
  endfunction
  task cmp(input [15:0] got, input [15:0] e);
  begin
    checks_done = checks_done + 1;
    if (got !== e)
    begin
      err_total = err_total + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    exp_q.push_back(e);
    host.put(1'h0, a, 8'h00);
  end
  endtask
  task end_of_test;
  begin
    cmp({15'h0000, exp_q.size() != 0}, 16'h0000); // every noted read must have been answered
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // read answers matched against the oldest note, mid-cycle when settled
  // an answer with no note pending is itself a mismatch
  always @(negedge clk_sys_in)
    if (reg_rvalid_out === 1'h1)
    begin
      if (exp_q.size() > 0)
        cmp(reg_rdata_out, exp_q.pop_front());
      else
        cmp(reg_rvalid_out, 16'h0000);
    end
  // hang guard, far beyond the run's roughly 140 cycles
  initial
  begin
    #20000;
    err_total = err_total + 1;
    end_of_test;
  end
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    #1 nrst_in = 1'h1;
    for (i = 0; i < 11; i = i + 1)
      rd(i[7:0] + 8'h09, rst_val(i));
    for (i = 4; i < 12; i = i + 1)
    begin
      rnd = $random(seed);
      host.put(1'h1, i[7:0] + 8'h09, rnd[7:0]);
      rd(i[7:0] + 8'h09, rst_val(i));
    end
    $display("reset and read-only test done");
    for (i = 0; i < 9; i = i + 1)
    begin
      rnd = (i < 3) ? 32'h0 : (i < 6) ? 32'h80 : $random(seed);
      host.put(1'h1, i[7:0] % 3 + 8'h09, rnd[7:0]);
      rd(i[7:0] % 3 + 8'h09, rnd[7:0]);
      case (i % 3)
        0: cmp(gain_factor_out, (rnd[7:0] == 8'h00) ? 16'h0100 : {8'h00, rnd[7:0]});
        1: cmp(first_offset_out, {{8{rnd[7]}}, rnd[7:0]});
        default: cmp(second_offset_out, {{8{rnd[7]}}, rnd[7:0]});
      endcase
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      {angle_en_in, gain_axis_select_in} = i[1:0];
      repeat (2) @(posedge clk_sys_in);
      #1 cmp(gain_axis_out, i[1] ? i[1:0] - 16'h1 : 16'h0);
    end
    $display("calibration test done");
    rnd = $random(seed);
    {temp_done_in, x_done_in} = 2'h3;
    @(posedge clk_sys_in);
    #1 {temp_done_in, x_done_in} = 2'h0;
    rd(8'h10, rnd[15:8]);
    rd(8'h11, rnd[7:0]);
    rd(8'h12, rnd[31:24]);
    rd(8'h13, rnd[23:16]);
    $display("result test done");
    // programmed address, then a power cycle that must drop it
    host.put(1'h1, 8'h0C, 8'h21);
    repeat (3) @(posedge clk_sys_in);
    #1 cmp(bus_target_addr_out, 16'h0010);
    host.put(1'h1, 8'h0C, 8'h40);
    repeat (3) @(posedge clk_sys_in);
    #1 cmp(bus_target_addr_out, 16'h0010);
    rd(8'h0C, 8'h40);
    repeat (2) @(posedge clk_sys_in);
    #1 nrst_in = 1'h0;
    #1 cmp(bus_target_addr_out, 16'h0035);
    repeat (2) @(posedge clk_sys_in);
    #1 nrst_in = 1'h1;
    rd(8'h12, 8'h00);
    host.put(1'h1, 8'h0C, 8'h21);
    repeat (3) @(posedge clk_sys_in);
    #1 cmp(bus_target_addr_out, 16'h0010);
    $display("address test done");
    repeat (3) @(posedge clk_sys_in);
    end_of_test;
  end
endmodule // hscr_regs_bench
